// File: ambient_window_cfg.svh
// Purpose: Offsets, reset values, field positions for the ambient/emitter slice
// Assumes: Byte-wide register file addressed by an 8-bit index
// Notes:   Include once per compilation unit; guard below
`ifndef AMBIENT_WINDOW_CFG_SVH
`define AMBIENT_WINDOW_CFG_SVH

// Register offsets
`define OFS_LOWER_LSB      8'h0B
`define OFS_LOWER_MSB      8'h0C
`define OFS_UPPER_LSB      8'h0D
`define OFS_UPPER_MSB      8'h0E
`define OFS_EMIT_ONE_TWO   8'h0F
`define OFS_EMIT_THREE     8'h10

// Reset values
`define RST_BYTE           8'h00
`define RST_NIBBLE         4'h0
`define RST_WORD           16'h0000

// Emitter current field positions
`define EMIT_TWO_HI        7
`define EMIT_TWO_LO        4
`define EMIT_ONE_HI        3
`define EMIT_ONE_LO        0

// Current code limits
`define CODE_NO_CURRENT    4'h0
`define CODE_MIN_STEP      4'h1
`define CODE_MAX_STEP      4'hF

// Compressed threshold fields and expansion constants
`define CMP_EXP_HI         7
`define CMP_EXP_LO         4
`define CMP_MANT_HI        3
`define CMP_MANT_LO        0
`define CMP_HIDDEN_BIT     5'h1_0
`define CMP_EXP_BIAS       4'h4

`endif

// File: ambient_window_pkg.sv
// Purpose: Types shared by the ambient window and emitter current slice
// Assumes: Three emitter outputs
// Notes:   Constants live in ambient_window_cfg.svh
package ambient_window_pkg;

    // Number of emitter outputs
    localparam int EMITTERS = 3;

    // Complete registered state of the slice
    typedef struct packed {
        logic [7:0]  lower_lsb;      // Lower bound, low byte
        logic [7:0]  lower_msb;      // Lower bound, high byte
        logic [7:0]  upper_lsb;      // Upper bound, low byte
        logic [7:0]  upper_msb;      // Upper bound, high byte
        logic [7:0]  emit_one_two;   // Emitter two (hi) and one (lo) codes
        logic [3:0]  emit_three;     // Emitter three code
        logic [7:0]  rdata;          // Read data holding register
        logic        irq;            // Ambient interrupt request pulse
        logic        below;          // Last result fell below lower bound
        logic        above;          // Last result rose above upper bound
        logic [11:0] drive_level;    // Per-emitter step, 4 bits each
        logic [2:0]  drive_on;       // Per-emitter sink enable
    } slice_state_t;

endpackage : ambient_window_pkg

// File: ambient_window_regs.sv
// Purpose: Ambient threshold window and emitter current registers
// Assumes: One clock; register port driven by the serial interface engine
// Notes:   Comparison is done here; interrupt status lives outside
//          Bounds are live on every byte write, so the host pauses
//          autonomous measurement while it rewrites a bound
//          Compressed bounds apply only while the revision strap is high
//          Emitter codes reach the drivers two cycles after a write strobe, during proximity phases
//
// Overview of operation
// - Lower bound: 16 bits at 0x0B/0x0C
// - Upper bound: 16 bits at 0x0D/0x0E
// - Window on visible or infrared result
// - Legacy revision: 8-bit compressed bound
// - Bits 7:4 of 0x0F drive emitter two
// - Bits 3:0 of 0x0F drive emitter one
// - Bits 3:0 of 0x10 drive emitter three
// - Code 0 off, 1 minimum, 15 maximum
// - All slice registers reset to zero
`include "ambient_window_cfg.svh"

module ambient_window_regs #(
    parameter int RESULT_W = 16,     // Width of ambient results
    parameter int CODE_W   = 4       // Width of an emitter current code
) (
    // Clock and reset
    input  wire logic                CLK,
    input  wire logic                RESET_N,
    // Register port from the serial interface engine
    input  wire logic [7:0]          REG_ADDR,
    input  wire logic                REG_WR,
    input  wire logic [7:0]          REG_WDATA,
    input  wire logic                REG_RD,
    output logic      [7:0]          REG_RDATA,
    // Revision strap: bounds held in compressed form
    input  wire logic                LEGACY_COMPRESSED,
    // Ambient measurement results
    input  wire logic [RESULT_W-1:0] VISIBLE_LIGHT_RESULT,
    input  wire logic [RESULT_W-1:0] INFRARED_LIGHT_RESULT,
    input  wire logic                RESULT_USE_INFRARED,
    input  wire logic                RESULT_VALID,
    // Window outcome
    output logic                     AMBIENT_IRQ,
    output logic                     AMBIENT_BELOW,
    output logic                     AMBIENT_ABOVE,
    // Proximity measurement phase
    input  wire logic                PROXIMITY_MEASUREMENT,
    // Emitter drive
    output logic [CODE_W-1:0]        EMITTER_ONE_OUTPUT,
    output logic [CODE_W-1:0]        EMITTER_TWO_OUTPUT,
    output logic [CODE_W-1:0]        EMITTER_THREE_OUTPUT,
    output logic [2:0]               EMITTER_ON
);

    // Registered state and its next value
    ambient_window_pkg::slice_state_t state_ff;
    ambient_window_pkg::slice_state_t nxt_state;

    // Effective 16-bit bounds used by the comparator
    logic [15:0] lower_bound;
    logic [15:0] upper_bound;
    // Result chosen for the window
    logic [15:0] chosen_result;
    // Raw codes per emitter
    logic [3:0]  emitter_code [ambient_window_pkg::EMITTERS];
    // Decoded step and enable per emitter
    logic [3:0]  emitter_step [ambient_window_pkg::EMITTERS];
    logic [2:0]  emitter_live;
    // Window outcome of the result presented this cycle
    logic        result_below;
    logic        result_above;

    // Expand an 8-bit compressed bound: hidden bit, 4-bit mantissa,
    // 4-bit exponent biased by four; zero stays zero
    function automatic logic [15:0] expand_bound(input logic [7:0] cmp);
        logic [3:0]  ex;
        logic [20:0] full;
        // Exponent nibble picks the shift, mantissa sits under it
        ex   = cmp[`CMP_EXP_HI:`CMP_EXP_LO];
        full = {16'h0000, `CMP_HIDDEN_BIT | {1'b0,
                cmp[`CMP_MANT_HI:`CMP_MANT_LO]}};
        if (cmp == `RST_BYTE)
        begin
            // A zero byte gives a bound of zero, not the hidden-bit value
            expand_bound = `RST_WORD;
        end
        else if (ex >= `CMP_EXP_BIAS)
        begin
            // Exponent above the bias scales the value up; at the bias it is unchanged
            full = full << (ex - `CMP_EXP_BIAS);
            expand_bound = full[15:0];
        end
        else
        begin
            // Small exponents scale the value down
            full = full >> (`CMP_EXP_BIAS - ex);
            expand_bound = full[15:0];
        end
    endfunction : expand_bound

    // Bound selection: plain word or compressed low byte
    // Legacy mode ignores the high bytes entirely
    always_comb
    begin
        if (LEGACY_COMPRESSED)
        begin
            // Older revisions keep only a compressed byte
            lower_bound = expand_bound(state_ff.lower_lsb);
            upper_bound = expand_bound(state_ff.upper_lsb);
        end
        else
        begin
            // Two bytes form each 16-bit bound
            lower_bound = {state_ff.lower_msb, state_ff.lower_lsb};
            upper_bound = {state_ff.upper_msb, state_ff.upper_lsb};
        end
    end

    // Result source for the window
    always_comb
    begin
        if (RESULT_USE_INFRARED)
        begin
            // Infrared channel feeds the window
            chosen_result = INFRARED_LIGHT_RESULT[15:0];
        end
        else
        begin
            // Visible channel feeds the window
            chosen_result = VISIBLE_LIGHT_RESULT[15:0];
        end
    end

    // Strict compares: a result equal to a bound lies inside the window
    assign result_below = chosen_result < lower_bound;
    assign result_above = chosen_result > upper_bound;

    // Code fields feeding the emitter decoders
    // Emitter three has only a low nibble; the rest is reserved
    assign emitter_code[0] =
        state_ff.emit_one_two[`EMIT_ONE_HI:`EMIT_ONE_LO];
    assign emitter_code[1] =
        state_ff.emit_one_two[`EMIT_TWO_HI:`EMIT_TWO_LO];
    assign emitter_code[2] = state_ff.emit_three;

    // Per-emitter decode: code 0 sinks nothing, 1..15 select a step
    // One decoder per emitter, gated only by the proximity phase
    genvar g;
    generate
        for (g = 0; g < ambient_window_pkg::EMITTERS; g++)
        begin : g_emitter
            // Enabled only for a nonzero code while measuring
            assign emitter_live[g] = PROXIMITY_MEASUREMENT &&
                (emitter_code[g] != `CODE_NO_CURRENT);
            // Step index passed to the driver, zero when idle
            assign emitter_step[g] = emitter_live[g] ?
                emitter_code[g] : `CODE_NO_CURRENT;
        end
    endgenerate

    // Next-state logic for the whole slice
    always_comb
    begin
        nxt_state = state_ff;
        // Fields not touched below keep their held value
        // Host writes; bounds are taken as written, so the host must pause
        // autonomous measurement first or a half-updated bound is seen
        if (REG_WR)
        begin
            case (REG_ADDR)
                `OFS_LOWER_LSB:
                begin
                    // Low byte of the lower bound
                    nxt_state.lower_lsb = REG_WDATA;
                end
                `OFS_LOWER_MSB:
                begin
                    // High byte of the lower bound
                    nxt_state.lower_msb = REG_WDATA;
                end
                `OFS_UPPER_LSB:
                begin
                    // Low byte of the upper bound
                    nxt_state.upper_lsb = REG_WDATA;
                end
                `OFS_UPPER_MSB:
                begin
                    // High byte of the upper bound
                    nxt_state.upper_msb = REG_WDATA;
                end
                `OFS_EMIT_ONE_TWO:
                begin
                    // Both nibbles land together
                    nxt_state.emit_one_two = REG_WDATA;
                end
                `OFS_EMIT_THREE:
                begin
                    // Upper nibble reserved, not stored
                    nxt_state.emit_three =
                        REG_WDATA[`EMIT_ONE_HI:`EMIT_ONE_LO];
                end
                default:
                begin
                    // Writes elsewhere belong to other slices
                end
            endcase
        end
        // Host reads return one cycle later and stand until the next read
        if (REG_RD)
        begin
            case (REG_ADDR)
                `OFS_LOWER_LSB:
                begin
                    nxt_state.rdata = state_ff.lower_lsb;
                end
                `OFS_LOWER_MSB:
                begin
                    nxt_state.rdata = state_ff.lower_msb;
                end
                `OFS_UPPER_LSB:
                begin
                    nxt_state.rdata = state_ff.upper_lsb;
                end
                `OFS_UPPER_MSB:
                begin
                    nxt_state.rdata = state_ff.upper_msb;
                end
                `OFS_EMIT_ONE_TWO:
                begin
                    nxt_state.rdata = state_ff.emit_one_two;
                end
                `OFS_EMIT_THREE:
                begin
                    // Reserved bits read as zero
                    nxt_state.rdata =
                        {`RST_NIBBLE, state_ff.emit_three};
                end
                default:
                begin
                    // Unmapped offsets read zero; other slices answer
                    nxt_state.rdata = `RST_BYTE;
                end
            endcase
        end
        // Window check on each new result
        // The request is a single-cycle pulse; flags hold between results
        nxt_state.irq = 1'b0;
        if (RESULT_VALID)
        begin
            // Flags record which side of the window was crossed
            nxt_state.below = result_below;
            nxt_state.above = result_above;
            // Any crossing raises the request
            nxt_state.irq   = result_below || result_above;
        end
        // Emitter drive follows the codes during proximity phases
        // Registering here keeps decode glitches off the emitter pins
        nxt_state.drive_level = {emitter_step[2], emitter_step[1],
                                 emitter_step[0]};
        nxt_state.drive_on    = emitter_live;
        // Synchronous reset clears everything
        // Reset wins over any write or result in the same cycle
        if (!RESET_N)
        begin
            // Host-visible registers
            nxt_state.lower_lsb    = `RST_BYTE;
            nxt_state.lower_msb    = `RST_BYTE;
            nxt_state.upper_lsb    = `RST_BYTE;
            nxt_state.upper_msb    = `RST_BYTE;
            nxt_state.emit_one_two = `RST_BYTE;
            nxt_state.emit_three   = `RST_NIBBLE;
            // Read data, window flags and emitter drive
            nxt_state.rdata        = `RST_BYTE;
            nxt_state.irq          = 1'b0;
            nxt_state.below        = 1'b0;
            nxt_state.above        = 1'b0;
            nxt_state.drive_level  = {3{`RST_NIBBLE}};
            nxt_state.drive_on     = 3'b000;
        end
    end

    // State register
    // No clock enable: every part of the slice moves on each edge
    always_ff @(posedge CLK)
    begin
        state_ff <= nxt_state;
    end

    // Outputs straight from flip-flops
    assign REG_RDATA            = state_ff.rdata;
    // Window outcome
    assign AMBIENT_IRQ          = state_ff.irq;
    assign AMBIENT_BELOW        = state_ff.below;
    assign AMBIENT_ABOVE        = state_ff.above;
    // Emitter drive, one step code per emitter
    assign EMITTER_ONE_OUTPUT   = state_ff.drive_level[3:0];
    assign EMITTER_TWO_OUTPUT   = state_ff.drive_level[7:4];
    assign EMITTER_THREE_OUTPUT = state_ff.drive_level[11:8];
    assign EMITTER_ON           = state_ff.drive_on;

endmodule : ambient_window_regs

// File: ambient_window_regs_assertions.sv
// Purpose: Port-level checks of the ambient window and emitter slice
// Assumes: 16-bit results, registered outputs, synchronous reset
// Notes:   Bounds are shadowed from the writes seen at the port
module ambient_window_checker #(
    parameter int RESULT_W = 16,
    parameter int CODE_W   = 4
) (
    // Clock, reset and register port
    input wire logic                CLK,
    input wire logic                RESET_N,
    input wire logic [7:0]          REG_ADDR,
    input wire logic                REG_WR,
    input wire logic [7:0]          REG_WDATA,
    input wire logic                REG_RD,
    input wire logic [7:0]          REG_RDATA,
    // Results and window outcome
    input wire logic                LEGACY_COMPRESSED,
    input wire logic [RESULT_W-1:0] VISIBLE_LIGHT_RESULT,
    input wire logic [RESULT_W-1:0] INFRARED_LIGHT_RESULT,
    input wire logic                RESULT_USE_INFRARED,
    input wire logic                RESULT_VALID,
    input wire logic                AMBIENT_IRQ,
    input wire logic                AMBIENT_BELOW,
    input wire logic                AMBIENT_ABOVE,
    // Emitter drive
    input wire logic                PROXIMITY_MEASUREMENT,
    input wire logic [CODE_W-1:0]   EMITTER_ONE_OUTPUT,
    input wire logic [CODE_W-1:0]   EMITTER_TWO_OUTPUT,
    input wire logic [CODE_W-1:0]   EMITTER_THREE_OUTPUT,
    input wire logic [2:0]          EMITTER_ON
);
    logic [15:0]         lo_ff;  // Shadow of lower bound
    logic [15:0]         hi_ff;  // Shadow of upper bound
    logic [RESULT_W-1:0] sel;    // Result under test
    assign sel = RESULT_USE_INFRARED ? INFRARED_LIGHT_RESULT
                                     : VISIBLE_LIGHT_RESULT;
    // Track bound bytes as the host writes them
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            lo_ff <= 16'h0000;
            hi_ff <= 16'h0000;
        end
        else if (REG_WR)
        begin
            case (REG_ADDR)
                8'h0B: lo_ff[7:0]  <= REG_WDATA;
                8'h0C: lo_ff[15:8] <= REG_WDATA;
                8'h0D: hi_ff[7:0]  <= REG_WDATA;
                8'h0E: hi_ff[15:8] <= REG_WDATA;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // A result taken while bounds are plain words
    sequence s_plain_take;
        RESULT_VALID && !LEGACY_COMPRESSED;
    endsequence
    a_below_exact: assert property (
        s_plain_take |=> AMBIENT_BELOW == ($past(sel) < $past(lo_ff)))
        else $error("below flag wrong");
    a_above_exact: assert property (
        s_plain_take |=> AMBIENT_ABOVE == ($past(sel) > $past(hi_ff)))
        else $error("above flag wrong");
    a_irq_cause: assert property (
        RESULT_VALID |=> AMBIENT_IRQ == (AMBIENT_BELOW || AMBIENT_ABOVE))
        else $error("irq does not match flags");
    a_irq_pulse: assert property (
        !RESULT_VALID |=> !AMBIENT_IRQ) else $error("irq without result");
    a_flags_hold: assert property (
        !RESULT_VALID |=> $stable({AMBIENT_BELOW, AMBIENT_ABOVE}))
        else $error("flags moved without result");
    a_emit_idle: assert property (
        !PROXIMITY_MEASUREMENT |=> EMITTER_ON == 3'b000 && {EMITTER_ONE_OUTPUT,
        EMITTER_TWO_OUTPUT, EMITTER_THREE_OUTPUT} == '0)
        else $error("emitter driven while idle");
    a_emit_on: assert property (
        EMITTER_ON == {|EMITTER_THREE_OUTPUT, |EMITTER_TWO_OUTPUT,
        |EMITTER_ONE_OUTPUT}) else $error("enable differs from code");
    a_reserved_zero: assert property (
        REG_RD && REG_ADDR == 8'h10 |=> REG_RDATA[7:4] == 4'h0)
        else $error("reserved bits read back");
    a_reset_clear: assert property (disable iff (1'b0)
        !RESET_N |=> REG_RDATA == 8'h00 && EMITTER_ON == 3'b000)
        else $error("outputs not cleared by reset");
endmodule : ambient_window_checker

// File: host_model.sv
// Purpose: Host side of the register port, byte writes and reads
// Assumes: One request at a time, driven 1 ns after the rising edge
// Notes:   Released buses carry inverted data so stale values never pass
module host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial reg_wr = 1'b0;
    initial reg_rd = 1'b0;
    initial reg_addr = 8'hFF;
    initial reg_wdata = 8'hFF;
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    // One-cycle read strobe, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : host_model

// File: ambient_window_and_emitter_current_regs_bench.sv
// Purpose: Self-checking bench for the ambient window and emitter slice
// Assumes: Host model owns the register port
// Notes:   Results are only presented while the bounds are not changing
module ambient_window_and_emitter_current_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset_n, legacy, use_ir, valid, prox;
    logic [15:0] vis, ir;          // Ambient results
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd;
    logic        irq, below, above;
    logic [3:0]  e_one, e_two, e_three;
    logic [2:0]  e_on;
    int          n_fail, compares, cycles;
    ambient_window_regs ambient_window_regs_inst (.CLK(clk),
        .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .LEGACY_COMPRESSED(legacy), .VISIBLE_LIGHT_RESULT(vis),
        .INFRARED_LIGHT_RESULT(ir), .RESULT_USE_INFRARED(use_ir),
        .RESULT_VALID(valid), .AMBIENT_IRQ(irq), .AMBIENT_BELOW(below),
        .AMBIENT_ABOVE(above), .PROXIMITY_MEASUREMENT(prox),
        .EMITTER_ONE_OUTPUT(e_one), .EMITTER_TWO_OUTPUT(e_two),
        .EMITTER_THREE_OUTPUT(e_three), .EMITTER_ON(e_on));
    host_model host_model_inst (.clk(clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_model_inst.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rd_chk
    // Present one result, check irq, below, above
    task automatic meas(input logic [15:0] v, input logic [15:0] i,
                        input logic u, input logic [2:0] exp);
        @(posedge clk);
        #1;
        vis = v;
        ir = i;
        use_ir = u;
        valid = 1'b1;
        @(posedge clk);
        #1;
        valid = 1'b0;
        chk({13'h0000, irq, below, above}, {13'h0000, exp});
    endtask : meas
    // Emitter outputs one cycle on
    task automatic emit(input logic [15:0] exp);
        @(posedge clk);
        #1;
        chk({e_one, e_two, e_three, 1'b0, e_on}, exp);
    endtask : emit
    // Registers read zero after the power-on reset
    task automatic reset_values();
        for (int a = 11; a <= 17; a++)
            rd_chk(8'(a), 8'h00);
    endtask : reset_values
    // Bytes 0x0B..0x0F keep what was written; reserved nibble and 0x11 read zero
    task automatic readback();
        for (int a = 11; a <= 17; a++)
            host_model_inst.wr(8'(a), ~8'(a));
        for (int a = 11; a <= 15; a++)
            rd_chk(8'(a), ~8'(a));
        rd_chk(8'h10, 8'h0F);
        rd_chk(8'h11, 8'h00);
    endtask : readback
    // Plain 16-bit window on visible then infrared results
    task automatic plain_window();
        // Bounds change only while no result is presented
        host_model_inst.wr(8'h0B, 8'h00);
        host_model_inst.wr(8'h0C, 8'h01);
        host_model_inst.wr(8'h0D, 8'h00);
        host_model_inst.wr(8'h0E, 8'h02);
        meas(16'h00FF, 16'h0150, 1'b0, 3'b110);
        meas(16'h0100, 16'h0000, 1'b0, 3'b000);
        meas(16'h0200, 16'hFFFF, 1'b0, 3'b000);
        meas(16'h0201, 16'h0150, 1'b0, 3'b101);
        meas(16'h0150, 16'h00FF, 1'b1, 3'b110);
        meas(16'h0150, 16'h0201, 1'b1, 3'b101);
        meas(16'h0150, 16'h0150, 1'b1, 3'b000);
    endtask : plain_window
    // Emitter codes drive only during proximity phases
    task automatic emitters();
        host_model_inst.wr(8'h0F, 8'h1F);
        host_model_inst.wr(8'h10, 8'hF0);
        prox = 1'b1;
        emit({4'hF, 4'h1, 4'h0, 1'b0, 3'b011});
        host_model_inst.wr(8'h10, 8'h01);
        emit({4'hF, 4'h1, 4'h1, 1'b0, 3'b111});
        prox = 1'b0;
        emit(16'h0000);
    endtask : emitters
    // Compressed low bytes on the older revision
    task automatic legacy_window();
        legacy = 1'b1;
        host_model_inst.wr(8'h0B, 8'h45);
        host_model_inst.wr(8'h0D, 8'h50);
        meas(16'h0014, 16'h0000, 1'b0, 3'b110);
        meas(16'h0015, 16'h0000, 1'b0, 3'b000);
        meas(16'h0020, 16'h0000, 1'b0, 3'b000);
        meas(16'h0021, 16'h0000, 1'b0, 3'b101);
    endtask : legacy_window
    // Reset in mid-run clears written registers and window flags
    task automatic mid_reset();
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk({13'h0000, irq, below, above}, 16'h0000);
        for (int a = 11; a <= 16; a++)
            rd_chk(8'(a), 8'h00);
    endtask : mid_reset
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            close_out();
        end
    end
    initial
    begin
        {reset_n, legacy, use_ir, valid, prox, vis, ir} = '0;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        reset_values();
        readback();
        plain_window();
        emitters();
        legacy_window();
        mid_reset();
        close_out();
    end
endmodule : ambient_window_and_emitter_current_regs_bench
bind ambient_window_regs ambient_window_checker #(.RESULT_W(RESULT_W),
    .CODE_W(CODE_W)) checker_inst (.CLK(CLK), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .LEGACY_COMPRESSED(LEGACY_COMPRESSED),
    .VISIBLE_LIGHT_RESULT(VISIBLE_LIGHT_RESULT),
    .INFRARED_LIGHT_RESULT(INFRARED_LIGHT_RESULT),
    .RESULT_USE_INFRARED(RESULT_USE_INFRARED), .RESULT_VALID(RESULT_VALID),
    .AMBIENT_IRQ(AMBIENT_IRQ), .AMBIENT_BELOW(AMBIENT_BELOW),
    .AMBIENT_ABOVE(AMBIENT_ABOVE),
    .PROXIMITY_MEASUREMENT(PROXIMITY_MEASUREMENT),
    .EMITTER_ONE_OUTPUT(EMITTER_ONE_OUTPUT),
    .EMITTER_TWO_OUTPUT(EMITTER_TWO_OUTPUT),
    .EMITTER_THREE_OUTPUT(EMITTER_THREE_OUTPUT), .EMITTER_ON(EMITTER_ON));
